// ---- design/fab_pkg.sv ----
// How it works
// - Add op sums accumulator and register, updating carry, nibble, zero.
// - For add, add-with-carry and shift, target-pick 0 writes accumulator, 1 writes back the register.
// - Add-with-carry sums accumulator, register and carry; updates flags.
// - Shift right moves bits 7:1 to 6:0, old bit 0 to carry.
// - Shift right keeps result bit 7 equal to source bit 7.
// - Clear-bit zeroes chosen bit, keeps others and all flags.
// - Set-bit forces chosen bit to one, keeps others and flags.
// - Literal jump loads incremented counter plus signed 9-bit offset.
// - Accumulator jump loads incremented counter plus unsigned accumulator.
// - Both jumps take two instruction cycles.
// - Register operand addresses 128 locations, 0 to 127, in bank.
// - The second cycle of a redirect executes a no-operation.
package fab_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int PC_W = 15;
   localparam int OFS_W = 9;
   localparam int BIT_W = 3;
   localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_ADD = 3'b001,
      OP_ADDC = 3'b010,
      OP_ASR = 3'b011,
      OP_CLRB = 3'b100,
      OP_SETB = 3'b101,
      OP_JLIT = 3'b110,
      OP_JACC = 3'b111
   } fab_op_type;

   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_FLUSH = 1'b1
   } fab_state_type;

   typedef struct packed {
      fab_op_type op;
      logic [ADDR_W-1:0] reg_addr;
      logic target_pick;
      logic [BIT_W-1:0] bit_sel;
      logic [OFS_W-1:0] offset;
   } fab_instr_type;

   typedef struct packed {
      logic add_out;
      logic nibble_out;
      logic result_nil;
   } fab_flags_type;
endpackage : fab_pkg

// ---- design/fab_regmem.sv ----
`timescale 1ns/100ps
module fab_regmem #(
   parameter int DW = 8,
   parameter int AW = 7
) (
   // Clock
   input wire logic ref_clk,
   input wire logic clk_en,
   // Read port, data registered
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data,
   // Write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge ref_clk) begin
      if (clk_en) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end
endmodule : fab_regmem

// ---- design/fab_alu.sv ----
`timescale 1ns/100ps
module fab_alu #(
   parameter int DW = fab_pkg::DATA_W,
   parameter int PW = fab_pkg::PC_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   // Instruction from decoder
   input wire logic instr_valid,
   input wire fab_pkg::fab_instr_type instr,
   // Register file write-back
   output logic reg_wr_en,
   output logic [fab_pkg::ADDR_W-1:0] reg_wr_addr,
   output logic [DW-1:0] reg_wr_data,
   // Architectural state
   output logic [DW-1:0] acc,
   output fab_pkg::fab_flags_type flags,
   output logic [PW-1:0] program_counter,
   // Pipeline status
   output logic instr_ready,
   output logic nop_cycle
);
   // Two-phase execute: cycle A reads the register, cycle B writes it
   logic [DW-1:0] rd_data;
   logic phase_r, phase_nxt;
   fab_pkg::fab_instr_type hold_r, hold_nxt;
   fab_pkg::fab_state_type state_r, state_nxt;
   logic [DW-1:0] acc_r, acc_nxt;
   fab_pkg::fab_flags_type flags_r, flags_nxt;
   logic [PW-1:0] pc_r, pc_nxt;
   logic wr_en_r, wr_en_nxt;
   logic [fab_pkg::ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
   logic [DW-1:0] wr_data_r, wr_data_nxt;
   logic nop_r, nop_nxt;
   logic [DW:0] sum;
   logic [4:0] nib;
   logic [DW-1:0] result;
   logic [DW-1:0] bit_mask;
   logic carry_in;
   localparam int OFS_W = fab_pkg::OFS_W;

   fab_regmem #(.DW(DW), .AW(fab_pkg::ADDR_W)) u_mem (
      .ref_clk(ref_clk),
      .clk_en(clk_en),
      .rd_addr(instr.reg_addr),
      .rd_data(rd_data),
      .wr_en(wr_en_nxt),
      .wr_addr(wr_addr_nxt),
      .wr_data(wr_data_nxt)
   );

   // Data-memory ops need the register read cycle first
   function automatic logic needs_reg(fab_pkg::fab_op_type op);
      needs_reg = (op == fab_pkg::OP_ADD) || (op == fab_pkg::OP_ADDC) ||
                  (op == fab_pkg::OP_ASR) || (op == fab_pkg::OP_CLRB) ||
                  (op == fab_pkg::OP_SETB);
   endfunction : needs_reg

   always_comb begin
      phase_nxt = phase_r;
      hold_nxt = hold_r;
      state_nxt = state_r;
      acc_nxt = acc_r;
      flags_nxt = flags_r;
      pc_nxt = pc_r;
      wr_en_nxt = 1'b0;
      wr_addr_nxt = hold_r.reg_addr;
      wr_data_nxt = '0;
      nop_nxt = 1'b0;
      carry_in = (hold_r.op == fab_pkg::OP_ADDC) ? flags_r.add_out : 1'b0;
      sum = {1'b0, acc_r} + {1'b0, rd_data} + {{DW{1'b0}}, carry_in};
      nib = {1'b0, acc_r[3:0]} + {1'b0, rd_data[3:0]} + {4'h0, carry_in};
      bit_mask = {{(DW-1){1'b0}}, 1'b1} << hold_r.bit_sel;
      result = '0;
      case (state_r)
         fab_pkg::ST_FLUSH: begin
            // instr_ready is low, so no instruction is taken; nothing is executed
            nop_nxt = 1'b1;
            state_nxt = fab_pkg::ST_RUN;
            pc_nxt = pc_r + {{(PW-1){1'b0}}, 1'b1};
         end
         fab_pkg::ST_RUN: begin
            if (phase_r) begin
               phase_nxt = 1'b0;
               case (hold_r.op)
                  fab_pkg::OP_ADD, fab_pkg::OP_ADDC: begin
                     result = sum[DW-1:0];
                     flags_nxt.add_out = sum[DW];
                     flags_nxt.nibble_out = nib[4];
                     flags_nxt.result_nil = (sum[DW-1:0] == '0);
                  end
                  fab_pkg::OP_ASR: begin
                     result = {rd_data[DW-1], rd_data[DW-1:1]};
                     flags_nxt.add_out = rd_data[0];
                     flags_nxt.result_nil = (result == '0);
                  end
                  fab_pkg::OP_CLRB: begin
                     result = rd_data & ~bit_mask;
                  end
                  fab_pkg::OP_SETB: begin
                     result = rd_data | bit_mask;
                  end
                  default: begin
                     result = rd_data;
                  end
               endcase
               // Bit ops always write back; others follow target-pick
               if (hold_r.target_pick || hold_r.op == fab_pkg::OP_CLRB ||
                   hold_r.op == fab_pkg::OP_SETB) begin
                  wr_en_nxt = 1'b1;
                  wr_data_nxt = result;
               end else begin
                  acc_nxt = result;
               end
               pc_nxt = pc_r + {{(PW-1){1'b0}}, 1'b1};
            end else if (instr_valid) begin
               hold_nxt = instr;
               case (instr.op)
                  fab_pkg::OP_JLIT: begin
                     // pc_r still holds the jump's own address; the flush cycle adds one
                     pc_nxt = pc_r + {{(PW-OFS_W){instr.offset[OFS_W-1]}},
                                      instr.offset};
                     state_nxt = fab_pkg::ST_FLUSH;
                  end
                  fab_pkg::OP_JACC: begin
                     pc_nxt = pc_r + {{(PW-DW){1'b0}}, acc_r};
                     state_nxt = fab_pkg::ST_FLUSH;
                  end
                  default: begin
                     if (needs_reg(instr.op)) begin
                        phase_nxt = 1'b1;
                     end else begin
                        pc_nxt = pc_r + {{(PW-1){1'b0}}, 1'b1};
                     end
                  end
               endcase
            end
         end
         default: begin
            state_nxt = fab_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         phase_r <= 1'b0;
         hold_r <= '0;
         state_r <= fab_pkg::ST_RUN;
         acc_r <= fab_pkg::ACC_RESET;
         flags_r <= '0;
         pc_r <= fab_pkg::PC_RESET;
         wr_en_r <= 1'b0;
         wr_addr_r <= '0;
         wr_data_r <= '0;
         nop_r <= 1'b0;
      end else if (clk_en) begin
         phase_r <= phase_nxt;
         hold_r <= hold_nxt;
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         flags_r <= flags_nxt;
         pc_r <= pc_nxt;
         wr_en_r <= wr_en_nxt;
         wr_addr_r <= wr_addr_nxt;
         wr_data_r <= wr_data_nxt;
         nop_r <= nop_nxt;
      end
   end

   assign reg_wr_en = wr_en_r;
   assign reg_wr_addr = wr_addr_r;
   assign reg_wr_data = wr_data_r;
   assign acc = acc_r;
   assign flags = flags_r;
   assign program_counter = pc_r;
   // Decoder may only present a new instruction in an idle run cycle
   assign instr_ready = (state_r == fab_pkg::ST_RUN) && !phase_r;
   assign nop_cycle = nop_r;
endmodule : fab_alu

// ---- verif/fab_alu_props.sv ----
`timescale 1ns/100ps
module fab_alu_props (
   // Core inputs
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic instr_valid,
   input wire fab_pkg::fab_instr_type instr,
   // Core outputs
   input wire logic reg_wr_en,
   input wire logic [6:0] reg_wr_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic [7:0] acc,
   input wire fab_pkg::fab_flags_type flags,
   input wire logic [14:0] program_counter,
   input wire logic instr_ready,
   input wire logic nop_cycle
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   wire tk = clk_en && instr_valid && instr_ready;
   wire [2:0] op = instr.op;
   wire ar = op inside {fab_pkg::OP_ADD, fab_pkg::OP_ADDC, fab_pkg::OP_ASR};
   wire bt = op inside {fab_pkg::OP_CLRB, fab_pkg::OP_SETB};
   wire jl = op == fab_pkg::OP_JLIT;
   sequence s_jump;
      tk && (jl || op == fab_pkg::OP_JACC);
   endsequence
   sequence s_busy;
      !instr_ready ##1 instr_ready;
   endsequence
   sequence s_wr;
      ##2 reg_wr_en && reg_wr_addr == $past(instr.reg_addr, 2);
   endsequence
   property p_busy;
      tk && op != fab_pkg::OP_NONE |=> s_busy;
   endproperty
   property p_jlit_pc;
      tk && jl |=> program_counter == $past(program_counter)
         + {{6{$past(instr.offset[8])}}, $past(instr.offset)};
   endproperty
   property p_jacc_pc;
      tk && op == fab_pkg::OP_JACC |=>
         program_counter == $past(program_counter) + $past(acc);
   endproperty
   property p_nop;
      s_jump |-> ##2 nop_cycle ##1 !nop_cycle;
   endproperty
   property p_jflag;
      s_jump |=> $stable(flags) [*2];
   endproperty
   property p_bflag;
      tk && bt |=> $stable(flags) [*2];
   endproperty
   property p_bwr;
      tk && bt |-> s_wr;
   endproperty
   property p_tp0;
      tk && ar && !instr.target_pick |-> ##2 !reg_wr_en;
   endproperty
   property p_tp1;
      tk && ar && instr.target_pick |-> s_wr;
   endproperty
   property p_nil;
      tk && ar && instr.target_pick |->
         ##2 flags.result_nil == (reg_wr_data == 8'h00);
   endproperty
   a_busy: assert property (p_busy)
      else $error("core not busy for exactly one cycle after take");
   a_jlit_pc: assert property (p_jlit_pc)
      else $error("bad literal jump target");
   a_jacc_pc: assert property (p_jacc_pc)
      else $error("bad accumulator jump target");
   a_nop: assert property (p_nop)
      else $error("no single flush cycle after jump");
   a_jflag: assert property (p_jflag)
      else $error("jump changed flags");
   a_bflag: assert property (p_bflag)
      else $error("bit op changed flags");
   a_bwr: assert property (p_bwr)
      else $error("bit op write missing");
   a_tp0: assert property (p_tp0)
      else $error("memory written for accumulator target");
   a_tp1: assert property (p_tp1)
      else $error("register write-back missing");
   a_nil: assert property (p_nil)
      else $error("zero flag wrong");
endmodule : fab_alu_props
bind fab_alu fab_alu_props fab_alu_props_i (.ref_clk, .srst, .clk_en,
   .instr_valid, .instr, .reg_wr_en, .reg_wr_addr, .reg_wr_data, .acc,
   .flags, .program_counter, .instr_ready, .nop_cycle);

// ---- verif/fab_dec_model.sv ----
`timescale 1ns/100ps
module fab_dec_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Bench requests
   input wire logic req,
   input wire fab_pkg::fab_instr_type req_instr,
   output logic taken,
   // Decoder side of the core
   input wire logic instr_ready,
   output logic instr_valid = 1'b0,
   output fab_pkg::fab_instr_type instr
);
   fab_pkg::fab_instr_type hold_r = '0;
   // Idle fields flip so a core that reads them unasked goes wrong
   assign instr = instr_valid ? hold_r : fab_pkg::fab_instr_type'(~hold_r);
   always_ff @(posedge ref_clk) begin
      taken <= instr_valid && instr_ready;
      if (srst || (instr_valid && instr_ready))
         instr_valid <= 1'b0;
      else if (req) begin
         instr_valid <= 1'b1;
         hold_r <= req_instr;
      end
   end
endmodule : fab_dec_model

// ---- verif/fab_alu_bench.sv ----
`timescale 1ns/100ps
module fab_alu_bench;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic req = 1'b0;
   fab_pkg::fab_instr_type ri = '0;
   fab_pkg::fab_instr_type instr;
   fab_pkg::fab_flags_type flags;
   logic taken, instr_valid, reg_wr_en, instr_ready, nop_cycle;
   logic [6:0] reg_wr_addr;
   logic [7:0] reg_wr_data, acc;
   logic [14:0] program_counter, pc;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   initial forever #20 ref_clk = ~ref_clk;
   fab_dec_model fab_dec_model_i (.ref_clk, .srst, .req, .req_instr(ri),
      .taken, .instr_ready, .instr_valid, .instr);
   fab_alu fab_alu_i (.ref_clk, .srst, .clk_en(1'b1), .instr_valid, .instr,
      .reg_wr_en, .reg_wr_addr, .reg_wr_data, .acc, .flags,
      .program_counter, .instr_ready, .nop_cycle);
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task automatic chk_d(input logic [7:0] g, input logic [7:0] x);
      checks_done++;
      if (g !== x) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk_d
   task automatic chk_p(input logic [14:0] g, input logic [14:0] x);
      checks_done++;
      if (g !== x) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk_p
   // Returns one cycle after the take, when results have landed
   task automatic run(input logic [2:0] op, input logic [6:0] a,
      input logic t, input logic [2:0] b, input logic [8:0] o);
      int n;
      n = 0;
      @(posedge ref_clk);
      ri <= '{fab_pkg::fab_op_type'(op), a, t, b, o};
      req <= 1'b1;
      @(posedge ref_clk);
      req <= 1'b0;
      while (taken !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      // A request the core never takes is a failure, not a skip
      if (taken !== 1'b1)
         n_mismatch++;
      @(posedge ref_clk);
      #1;
      pc = pc + 15'h0001;
   endtask : run
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      pc = 15'h0000;
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      // Memory is not reset, so bits are built up one at a time
      for (int i = 0; i < 16; i++) begin
         if (i < 8)
            run(3'h5, 7'h7F, 1'b1, i[2:0], 9'h000);
         else
            run(3'h4, 7'h00, 1'b1, i[2:0], 9'h000);
         if (i % 8 == 7)
            chk_d(reg_wr_data, {8{i < 8}});
      end
      run(3'h4, 7'h7F, 1'b1, 3'h0, 9'h000);
      chk_d(reg_wr_data, 8'hFE);
      chk_d(8'(reg_wr_addr), 8'h7F);
      chk_d(8'(flags), 8'h00);
      run(3'h1, 7'h7F, 1'b0, 3'h0, 9'h000);
      chk_d(acc, 8'hFE);
      chk_d(8'(reg_wr_en), 8'h00);
      run(3'h1, 7'h7F, 1'b1, 3'h0, 9'h000);
      chk_d(reg_wr_data, 8'hFC);
      chk_d(8'(flags), 8'h06);
      run(3'h2, 7'h7F, 1'b0, 3'h0, 9'h000);
      chk_d(acc, 8'hFB);
      chk_d(8'(flags), 8'h06);
      run(3'h3, 7'h7F, 1'b1, 3'h0, 9'h000);
      chk_d(reg_wr_data, 8'hFE);
      chk_d(8'(flags), 8'h02);
      run(3'h3, 7'h00, 1'b0, 3'h0, 9'h000);
      chk_d(acc, 8'h00);
      chk_d(8'(flags), 8'h03);
      run(3'h3, 7'h7F, 1'b0, 3'h0, 9'h000);
      chk_d(acc, 8'hFF);
      chk_d(8'(instr_ready), 8'h01);
      chk_p(program_counter, pc);
      pc = pc + 15'h7F00;
      run(3'h6, 7'h00, 1'b0, 3'h0, 9'h100);
      chk_p(program_counter, pc);
      chk_d(8'(nop_cycle), 8'h01);
      pc = pc + 15'h00FF;
      run(3'h6, 7'h00, 1'b0, 3'h0, 9'h0FF);
      chk_p(program_counter, pc);
      pc = pc + 15'h00FF;
      run(3'h7, 7'h00, 1'b0, 3'h0, 9'h000);
      chk_p(program_counter, pc);
      chk_d(8'(flags), 8'h02);
      complete_run();
   end
endmodule : fab_alu_bench
